/* File: rtl/hple_cfg.svh */
/*
 * hple_cfg.svh: register offsets, reset values, field positions and octet,
 * supervisory, mode and crc codes of the protocol engine.
 * Assumes: included by bare name from the design files.
 */
`ifndef HPLE_CFG_SVH
`define HPLE_CFG_SVH

// ----------------------------------------------------------------
// octet, supervisory, mode and crc codes
// ----------------------------------------------------------------
`define HPLE_FLAG 8'h7e
`define HPLE_ESC 8'h7d
`define HPLE_FLIP 8'h20
`define HPLE_IDLE_ONES 8'hff
`define HPLE_ADDR_CMD 8'h03
`define HPLE_ADDR_RSP 8'h01
`define HPLE_S_RR 2'h0
`define HPLE_S_RNR 2'h1
`define HPLE_S_REJ 2'h2
`define HPLE_MODE_AUTO 3'h0
`define HPLE_MODE_XT 3'h7
`define HPLE_CRC_INIT 16'hffff
`define HPLE_CRC_POLY 16'h8408
`define HPLE_CRC_GOOD 16'hf0b8

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define HPLE_OFS_CTRL 8'h00
`define HPLE_OFS_MAP 8'h04
`define HPLE_OFS_UCH 8'h08
`define HPLE_OFS_TMR 8'h0c
`define HPLE_OFS_CMD 8'h10
`define HPLE_OFS_STAT 8'h14
`define HPLE_CTRL_RST 8'h00
`define HPLE_MAP_RST 32'h00000000
`define HPLE_UCH_RST 32'h7e7e7e7e
`define HPLE_T1_RST 16'h0100
`define HPLE_N1_RST 8'h03

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HPLE_CMD_XIF 0
`define HPLE_CMD_XTF 1
`define HPLE_CMD_RECEIVER_RESET_CMD 2
`define HPLE_EV_ALL_SENT_ACK_IRQ 0
`define HPLE_EV_XMR 1
`define HPLE_EV_TIN 2
`define HPLE_EV_RME 3
`define HPLE_EV_PCE 4
`define HPLE_EV_RSC 5

`endif

/* File: rtl/hple_engine.sv */
/*
 * hple_engine: octet-synchronous PPP framer, extended transparent channel and
 * auto-mode window-1 link procedure, with an APB register slave.
 * Assumes: line octets come and go on sync strobes in the clk domain (bit 0
 * is the first bit on the line); host streams run on clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "hple_cfg.svh"
module hple_engine (
	// system
	input wire logic clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// line side
	input wire logic lineRxSync,
	input wire logic carrierDetectStrobe,
	input wire logic [7:0] lineRxOctet,
	input wire logic lineTxSync,
	output logic [7:0] lineTxOctet,
	// host transmit stream
	input wire logic hostTxValid,
	input wire hple_pkg::hple_txd_s hostTx,
	output logic hostTxReady,
	// host receive stream and events
	output hple_pkg::hple_rxd_s hostRx,
	output logic [5:0] lapEvents
);
	import hple_pkg::*;

	// ----------------------------------------------------------------
	// mapping and crc
	// ----------------------------------------------------------------
	// flag and escape always hit, the map and user chars only with ppp; any hit escapes the octet
	function automatic logic mapped(input logic [7:0] b, input logic [31:0] map,
		input logic [31:0] uc, input logic ppp);
		logic hit;
		hit = (b == `HPLE_ESC) || (b == `HPLE_FLAG);
		if (ppp && b[7:5] == 3'h0)
			hit = hit | map[b[4:0]];
		for (int i = 0; i < 4; i++)
			hit = hit | (ppp && b == uc[8*i +: 8]);
		return hit;
	endfunction

	function automatic logic [15:0] crcNext(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ `HPLE_CRC_POLY) : (r >> 1);
		return r;
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	hple_ctrl_s ctrl_ff;
	logic [31:0] map_ff, uch_ff, prdata_ff;
	logic [15:0] t1_ff, tmr_ff, txCrc_ff, rxCrc_ff;
	logic [7:0] n1_ff, retry_ff, txOct_ff, escByte_ff, rxAddr_ff, rxC1_ff, rxC2_ff;
	logic [5:0] stat_ff, evt_ff;
	logic [3:0] rxCnt_ff;
	logic [2:0][7:0] hdr_ff;
	logic [1:0] hdrIdx_ff, hdrLen_ff, sType_ff;
	logic pready_ff, pslverr_ff, xifPend_ff, xtfPend_ff, sPend_ff, sCmd_ff, sPf_ff;
	logic escPend_ff, holdFull_ff, ready_ff, frmI_ff, frmS_ff, rxEsc_ff;
	logic vs_ff, vr_ff, waitAck_ff, busy_ff, late_ff;
	hple_txd_s hold_ff;
	hple_rxd_s hostRx_ff;
	hple_tx_e txSt_ff;
	hple_rx_e rxSt_ff;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire apbWr = psel && penable && pready_ff && pwrite;
	wire selCtrl = paddr == `HPLE_OFS_CTRL;
	wire selMap = paddr == `HPLE_OFS_MAP;
	wire selUch = paddr == `HPLE_OFS_UCH;
	wire selTmr = paddr == `HPLE_OFS_TMR;
	wire selCmd = paddr == `HPLE_OFS_CMD;
	wire selStat = paddr == `HPLE_OFS_STAT;
	wire regHit = selCtrl | selMap | selUch | selTmr | selCmd | selStat;
	wire [31:0] rdMux = selCtrl ? {24'h0, ctrl_ff} : selMap ? map_ff : selUch ? uch_ff :
		selTmr ? {8'h0, n1_ff, t1_ff} :
		selStat ? {20'h0, vr_ff, vs_ff, busy_ff, waitAck_ff, 2'b00, stat_ff} : 32'h0;
	wire receiver_reset_cmd = apbWr && selCmd && pwdata[`HPLE_CMD_RECEIVER_RESET_CMD];
	wire isAuto = ctrl_ff.modeSelect == `HPLE_MODE_AUTO;
	wire isXt = ctrl_ff.modeSelect == `HPLE_MODE_XT;
	wire modulo_count_select = ctrl_ff.moduloCountSelect;
	wire ppp = ctrl_ff.pppSubmode;

	// ----------------------------------------------------------------
	// transmit selection
	// ----------------------------------------------------------------
	wire txStep = lineTxSync && !escPend_ff;
	wire txStart = txStep && txSt_ff == TX_IDLE && !isXt;
	wire sTaken = txStart && sPend_ff;
	wire iTaken = txStart && !sPend_ff && xifPend_ff;
	wire tTaken = txStart && !sPend_ff && !xifPend_ff && xtfPend_ff;
	wire iSent = txStep && txSt_ff == TX_CLOSE && frmI_ff;
	wire [7:0] hAddr = (sPend_ff && !sCmd_ff) ? `HPLE_ADDR_RSP : `HPLE_ADDR_CMD;
	wire [7:0] hC1 = modulo_count_select ? (sPend_ff ? {4'h0, sType_ff, 2'b01} : {6'h0, vs_ff, 1'b0}) :
		(sPend_ff ? {2'b00, vr_ff, sPf_ff, sType_ff, 2'b01} : {2'b00, vr_ff, 3'b000, vs_ff, 1'b0});
	wire [7:0] hC2 = {6'h0, vr_ff, sPend_ff && sPf_ff};
	wire [7:0] dByte = txSt_ff == TX_HDR ? hdr_ff[hdrIdx_ff] : txSt_ff == TX_DATA ? hold_ff.data :
		txSt_ff == TX_CRC1 ? ~txCrc_ff[7:0] : ~txCrc_ff[15:8];
	wire dMap = mapped(dByte, map_ff, uch_ff, ppp);
	wire inFrmData = txSt_ff == TX_HDR || (txSt_ff == TX_DATA && holdFull_ff);
	wire emitNow = txStep && (inFrmData || txSt_ff == TX_CRC1 || txSt_ff == TX_CRC2);
	wire takeHost = hostTxValid && ready_ff;
	wire wantData = isXt || txSt_ff == TX_DATA;
	wire [7:0] fillOct = ctrl_ff.interframeFillSelect ? `HPLE_FLAG : `HPLE_IDLE_ONES;

	// ----------------------------------------------------------------
	// receive classification
	// ----------------------------------------------------------------
	wire rxTake = lineRxSync || (isXt && carrierDetectStrobe);
	wire [7:0] rb = lineRxOctet;
	wire [7:0] rd = rxEsc_ff ? rb ^ `HPLE_FLIP : rb;
	wire rxDrop = !rxEsc_ff && mapped(rb, map_ff, uch_ff, ppp);
	wire frameEnd = rxTake && !isXt && rb == `HPLE_FLAG && rxSt_ff == RX_FRAME &&
		(rxCnt_ff != 4'h0 || rxEsc_ff);
	wire fOk = !rxEsc_ff && rxCrc_ff == `HPLE_CRC_GOOD;
	wire isI = !rxC1_ff[0];
	wire isS = rxC1_ff[1:0] == 2'b01;
	wire nsL = rxC1_ff[1];
	wire nrL = modulo_count_select ? rxC2_ff[1] : rxC1_ff[5];
	wire pfB = modulo_count_select ? rxC2_ff[0] : rxC1_ff[4];
	wire [1:0] sTy = rxC1_ff[3:2];
	wire rxCmd = rxAddr_ff == `HPLE_ADDR_RSP;
	wire sInfo = rxCnt_ff > (modulo_count_select ? 4'd5 : 4'd4);
	wire nrBad = !waitAck_ff && nrL != vs_ff;
	wire acked = waitAck_ff && nrL != vs_ff;
	wire iRef = ctrl_ff.recvNotReady || nsL != vr_ff;
	wire lapDiscard = isAuto && fOk && (isS || (isI && (iRef || nrBad)));
	wire timerOn = (waitAck_ff && ctrl_ff.timerMode) || busy_ff || late_ff;
	wire expire = timerOn && tmr_ff <= 16'h1;
	wire [1:0] myS = ctrl_ff.recvNotReady ? `HPLE_S_RNR : `HPLE_S_RR;

	// ----------------------------------------------------------------
	// apb slave and configuration
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
			ctrl_ff <= hple_ctrl_s'(`HPLE_CTRL_RST);
			map_ff <= `HPLE_MAP_RST;
			uch_ff <= `HPLE_UCH_RST;
			t1_ff <= `HPLE_T1_RST;
			n1_ff <= `HPLE_N1_RST;
			xifPend_ff <= 1'b0;
			xtfPend_ff <= 1'b0;
			stat_ff <= 6'h0;
		end else begin
			pready_ff <= psel && !penable && !pready_ff;
			pslverr_ff <= psel && !penable && !regHit;
			prdata_ff <= rdMux;
			if (apbWr && selCtrl)
				ctrl_ff <= hple_ctrl_s'(pwdata[7:0]);
			if (apbWr && selMap)
				map_ff <= pwdata;
			if (apbWr && selUch)
				uch_ff <= pwdata;
			if (apbWr && selTmr) begin
				t1_ff <= pwdata[15:0];
				n1_ff <= pwdata[23:16];
			end
			if (iTaken || receiver_reset_cmd)
				xifPend_ff <= 1'b0;
			if (tTaken || receiver_reset_cmd)
				xtfPend_ff <= 1'b0;
			if (apbWr && selCmd && pwdata[`HPLE_CMD_XIF] && isAuto && !waitAck_ff)
				xifPend_ff <= 1'b1;
			if (apbWr && selCmd && pwdata[`HPLE_CMD_XTF])
				xtfPend_ff <= 1'b1;
			stat_ff <= (stat_ff & ~((apbWr && selStat) ? pwdata[5:0] : 6'h0)) | evt_ff;
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			txSt_ff <= TX_IDLE;
			txOct_ff <= `HPLE_IDLE_ONES;
			escPend_ff <= 1'b0;
			escByte_ff <= 8'h0;
			hold_ff <= '0;
			holdFull_ff <= 1'b0;
			ready_ff <= 1'b0;
			txCrc_ff <= `HPLE_CRC_INIT;
			hdr_ff <= '0;
			hdrIdx_ff <= 2'h0;
			hdrLen_ff <= 2'h0;
			frmI_ff <= 1'b0;
			frmS_ff <= 1'b0;
		end else begin
			ready_ff <= wantData && !holdFull_ff && !takeHost;
			if (takeHost) begin
				hold_ff <= hostTx;
				holdFull_ff <= 1'b1;
			end
			if (lineTxSync && escPend_ff) begin
				txOct_ff <= escByte_ff;
				escPend_ff <= 1'b0;
			end
			if (emitNow) begin
				txOct_ff <= dMap ? `HPLE_ESC : dByte;
				escByte_ff <= dByte ^ `HPLE_FLIP;
				escPend_ff <= dMap;
				if (inFrmData)
					txCrc_ff <= crcNext(txCrc_ff, dByte);
			end
			if (txStep) begin
				case (txSt_ff)
					TX_IDLE: begin
						if (isXt) begin
							txOct_ff <= holdFull_ff ? hold_ff.data : `HPLE_IDLE_ONES;
							holdFull_ff <= 1'b0;
						end else if (sTaken || iTaken || tTaken) begin
							txOct_ff <= `HPLE_FLAG;
							txSt_ff <= tTaken ? TX_DATA : TX_HDR;
							hdr_ff <= modulo_count_select ? {hC2, hC1, hAddr} : {8'h0, hC1, hAddr};
							hdrLen_ff <= modulo_count_select ? 2'd3 : 2'd2;
							hdrIdx_ff <= 2'h0;
							frmI_ff <= iTaken;
							frmS_ff <= sTaken;
							txCrc_ff <= `HPLE_CRC_INIT;
						end else
							txOct_ff <= fillOct;
					end
					TX_HDR: begin
						hdrIdx_ff <= hdrIdx_ff + 2'h1;
						if (hdrIdx_ff == hdrLen_ff - 2'h1)
							txSt_ff <= frmS_ff ? TX_CRC1 : TX_DATA;
					end
					TX_DATA: begin
						if (holdFull_ff) begin
							holdFull_ff <= 1'b0;
							if (hold_ff.last)
								txSt_ff <= TX_CRC1;
						end else begin
							txOct_ff <= `HPLE_ESC;
							escByte_ff <= `HPLE_FLAG;
							escPend_ff <= 1'b1;
							frmI_ff <= 1'b0;
							txSt_ff <= TX_IDLE;
						end
					end
					TX_CRC1: txSt_ff <= TX_CRC2;
					TX_CRC2: txSt_ff <= TX_CLOSE;
					TX_CLOSE: begin
						txOct_ff <= `HPLE_FLAG;
						txSt_ff <= TX_IDLE;
					end
					default: txSt_ff <= TX_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			rxSt_ff <= RX_HUNT;
			rxEsc_ff <= 1'b0;
			rxCrc_ff <= `HPLE_CRC_INIT;
			rxCnt_ff <= 4'h0;
			rxAddr_ff <= 8'h0;
			rxC1_ff <= 8'h0;
			rxC2_ff <= 8'h0;
			hostRx_ff <= '0;
		end else begin
			hostRx_ff.valid <= 1'b0;
			hostRx_ff.last <= 1'b0;
			if (receiver_reset_cmd)
				rxSt_ff <= RX_HUNT;
			else if (rxTake && isXt) begin
				hostRx_ff <= '{data: rb, valid: 1'b1, default: 1'b0};
			end else if (rxTake && rb == `HPLE_FLAG) begin
				rxSt_ff <= RX_FRAME;
				rxEsc_ff <= 1'b0;
				rxCnt_ff <= 4'h0;
				rxCrc_ff <= `HPLE_CRC_INIT;
				if (frameEnd)
					hostRx_ff <= '{data: 8'h0, valid: 1'b0, last: 1'b1, crcErr: !fOk,
						abort: rxEsc_ff, discard: lapDiscard};
			end else if (rxTake && rxSt_ff == RX_FRAME) begin
				if (rb == `HPLE_ESC && !rxEsc_ff)
					rxEsc_ff <= 1'b1;
				else if (rxDrop)
					rxEsc_ff <= 1'b0;
				else begin
					rxEsc_ff <= 1'b0;
					rxCrc_ff <= crcNext(rxCrc_ff, rd);
					if (rxCnt_ff != 4'hf)
						rxCnt_ff <= rxCnt_ff + 4'h1;
					if (rxCnt_ff == 4'h0)
						rxAddr_ff <= rd;
					if (rxCnt_ff == 4'h1)
						rxC1_ff <= rd;
					if (rxCnt_ff == 4'h2)
						rxC2_ff <= rd;
					hostRx_ff.data <= rd;
					hostRx_ff.valid <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// link procedure and timer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset || receiver_reset_cmd) begin
			vs_ff <= 1'b0;
			vr_ff <= 1'b0;
			waitAck_ff <= 1'b0;
			busy_ff <= 1'b0;
			late_ff <= 1'b0;
			retry_ff <= 8'h0;
			tmr_ff <= `HPLE_T1_RST;
			sPend_ff <= 1'b0;
			sCmd_ff <= 1'b0;
			sPf_ff <= 1'b0;
			sType_ff <= `HPLE_S_RR;
			evt_ff <= 6'h0;
		end else begin
			evt_ff <= 6'h0;
			if (sTaken)
				sPend_ff <= 1'b0;
			tmr_ff <= (!timerOn || expire) ? t1_ff : tmr_ff - 16'h1;
			if (iSent) begin
				waitAck_ff <= 1'b1;
				retry_ff <= 8'h0;
			end
			if (frameEnd) begin
				if (!isAuto || (!fOk && isI) || (fOk && !isI && !isS))
					evt_ff[`HPLE_EV_RME] <= 1'b1;
				else if (fOk && (nrBad || (isS && sInfo)))
					evt_ff[`HPLE_EV_PCE] <= 1'b1;
				else if (fOk) begin
					if (acked) begin
						vs_ff <= ~vs_ff;
						waitAck_ff <= 1'b0;
						retry_ff <= 8'h0;
						evt_ff[`HPLE_EV_ALL_SENT_ACK_IRQ] <= 1'b1;
					end else if (isS && waitAck_ff &&
						(sTy == `HPLE_S_REJ || (!rxCmd && pfB && retry_ff != 8'h0))) begin
						waitAck_ff <= 1'b0;
						retry_ff <= 8'h0;
						evt_ff[`HPLE_EV_XMR] <= 1'b1;
					end
					if (isI) begin
						sPend_ff <= 1'b1;
						sCmd_ff <= 1'b0;
						sPf_ff <= pfB;
						sType_ff <= myS;
						if (!iRef) begin
							vr_ff <= ~vr_ff;
							evt_ff[`HPLE_EV_RME] <= 1'b1;
						end
					end else begin
						if (sTy == `HPLE_S_RNR) begin
							busy_ff <= 1'b1;
							evt_ff[`HPLE_EV_RSC] <= !busy_ff;
						end else if (busy_ff) begin
							busy_ff <= 1'b0;
							retry_ff <= 8'h0;
							evt_ff[`HPLE_EV_RSC] <= 1'b1;
						end
						if (rxCmd && pfB) begin
							sPend_ff <= 1'b1;
							sCmd_ff <= 1'b0;
							sPf_ff <= 1'b1;
							sType_ff <= myS;
						end
					end
				end
			end else if (expire) begin
				if (late_ff) begin
					late_ff <= 1'b0;
					evt_ff[`HPLE_EV_ALL_SENT_ACK_IRQ] <= 1'b1;
				end else if (retry_ff < n1_ff) begin
					retry_ff <= retry_ff + 8'h1;
					sPend_ff <= 1'b1;
					sCmd_ff <= 1'b1;
					sPf_ff <= 1'b1;
					sType_ff <= myS;
				end else begin
					retry_ff <= 8'h0;
					waitAck_ff <= 1'b0;
					evt_ff[`HPLE_EV_TIN] <= 1'b1;
					if (busy_ff) begin
						busy_ff <= 1'b0;
						late_ff <= 1'b1;
					end
				end
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign lineTxOctet = txOct_ff;
	assign hostTxReady = ready_ff;
	assign hostRx = hostRx_ff;
	assign lapEvents = evt_ff;
endmodule // hple_engine
`default_nettype wire

/* File: rtl/hple_pkg.sv */
/*
 * hple_pkg: types of the protocol engine.
 * Assumes: compiled before the engine.
 */
package hple_pkg;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_HDR = 3'b001,
		TX_DATA = 3'b011,
		TX_CRC1 = 3'b010,
		TX_CRC2 = 3'b110,
		TX_CLOSE = 3'b111
	} hple_tx_e;
	typedef enum logic {RX_HUNT = 1'b0, RX_FRAME = 1'b1} hple_rx_e;
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} hple_txd_s;
	typedef struct packed {
		logic [7:0] data;
		logic valid;
		logic last;
		logic crcErr;
		logic abort;
		logic discard;
	} hple_rxd_s;
	typedef struct packed {
		logic [2:0] modeSelect;
		logic pppSubmode;
		logic moduloCountSelect;
		logic interframeFillSelect;
		logic recvNotReady;
		logic timerMode;
	} hple_ctrl_s;
endpackage

/* File: testbench/hple_engine_checker.sv */
/* hple_engine_checker: port assertions of the protocol engine.
   Assumes: bound to hple_engine; sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module hple_engine_checker (
	// system
	input wire logic clk,
	input wire logic reset,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// line and host
	input wire logic lineRxSync,
	input wire logic carrierDetectStrobe,
	input wire logic lineTxSync,
	input wire logic [7:0] lineTxOctet,
	input wire logic hostTxValid,
	input wire logic hostTxReady,
	input wire hple_pkg::hple_rxd_s hostRx,
	input wire logic [5:0] lapEvents
);
	import hple_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_apb_only: assert property (pready |-> $past(psel && !penable))
		else $error("answer without setup");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h14 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_rx_cause: assert property (hostRx.valid |-> $past(lineRxSync || carrierDetectStrobe))
		else $error("receive octet without strobe");
	a_tx_hold: assert property (!lineTxSync |=> $stable(lineTxOctet))
		else $error("line octet moved off strobe");
	a_take_drop: assert property (hostTxValid && hostTxReady |=> !hostTxReady)
		else $error("ready stayed after take");
	a_last_clean: assert property (hostRx.last |-> !hostRx.valid && hostRx.data == 8'h00)
		else $error("frame end carries data");
	a_event_pulse: assert property (|lapEvents |=> (lapEvents & $past(lapEvents)) == 6'h00)
		else $error("event longer than one cycle");
	a_reset_idle: assert property (disable iff (1'b0)
		reset |=> !pready && lineTxOctet == 8'hff && lapEvents == 6'h00 && !hostTxReady)
		else $error("outputs not idle after reset");
	c_refused: cover property (pslverr);
	c_timeout: cover property (lapEvents[2]);
	c_abort: cover property (hostRx.last && hostRx.abort);
endmodule // hple_engine_checker
bind hple_engine hple_engine_checker chk (.clk(clk), .reset(reset), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.lineRxSync(lineRxSync), .carrierDetectStrobe(carrierDetectStrobe),
	.lineTxSync(lineTxSync), .lineTxOctet(lineTxOctet), .hostTxValid(hostTxValid),
	.hostTxReady(hostTxReady), .hostRx(hostRx), .lapEvents(lapEvents));
`default_nettype wire

/* File: testbench/hple_line_partner.sv */
/* hple_line_partner: remote station on the octet line.
   Assumes: same clk as the engine; the bench calls send and reads txq. */
`timescale 1ns/1ns
`default_nettype none
module hple_line_partner (
	// system
	input wire logic clk,
	// line
	output logic lineRxSync,
	output logic carrierDetectStrobe,
	output logic [7:0] lineRxOctet,
	output logic lineTxSync,
	input wire logic [7:0] lineTxOctet
);
	logic [1:0] phase;
	logic seen;
	logic [7:0] txq[$];
	initial begin
		lineRxSync = 1'b0;
		carrierDetectStrobe = 1'b0;
		lineRxOctet = 8'h00;
		lineTxSync = 1'b0;
		phase = 2'h0;
		seen = 1'b0;
	end
	// ----------------------------------------------------------------
	// octet sync strobe and capture of sent octets
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		phase <= phase + 2'h1;
		lineTxSync <= (phase == 2'h3);
		seen <= lineTxSync;
		if (seen) begin
			txq.push_back(lineTxOctet);
		end
	end
	// one octet every four cycles, on sync or on the carrier strobe
	task automatic send(input logic [7:0] b, input logic viaCd);
		repeat (3) @(posedge clk);
		lineRxOctet <= b;
		lineRxSync <= !viaCd;
		carrierDetectStrobe <= viaCd;
		@(posedge clk);
		lineRxSync <= 1'b0;
		carrierDetectStrobe <= 1'b0;
		lineRxOctet <= ~b;
	endtask
endmodule // hple_line_partner
`default_nettype wire

/* File: testbench/tb.sv */
/* tb: self-checking bench of the protocol engine.
   Assumes: hple_engine, its checker and the line partner are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb;
	import hple_pkg::*;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr, lineRxOctet, lineTxOctet;
	logic [31:0] pwdata, prdata, rd;
	logic lineRxSync, carrierDetectStrobe, lineTxSync, hostTxValid, hostTxReady;
	hple_txd_s hostTx;
	hple_rxd_s hostRx;
	logic [5:0] lapEvents;
	int err_count, n_tests, cyc, lastCnt, abortCnt, tinCnt;
	logic [2:0] lastFlags;
	logic [7:0] rxq[$];
	logic [7:0] rxs[$];

	hple_engine uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lineRxSync(lineRxSync), .carrierDetectStrobe(carrierDetectStrobe),
		.lineRxOctet(lineRxOctet), .lineTxSync(lineTxSync), .lineTxOctet(lineTxOctet),
		.hostTxValid(hostTxValid), .hostTx(hostTx), .hostTxReady(hostTxReady),
		.hostRx(hostRx), .lapEvents(lapEvents));
	hple_line_partner partner (.clk(clk), .lineRxSync(lineRxSync),
		.carrierDetectStrobe(carrierDetectStrobe), .lineRxOctet(lineRxOctet),
		.lineTxSync(lineTxSync), .lineTxOctet(lineTxOctet));

	initial clk = 1'b0;
	always #25 clk = ~clk;

	// ----------------------------------------------------------------
	// monitors and timeout
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (hostRx.valid === 1'b1) begin
			rxq.push_back(hostRx.data);
		end
		if (hostRx.last === 1'b1) begin
			lastCnt++;
			lastFlags = {hostRx.crcErr, hostRx.abort, hostRx.discard};
			if (hostRx.abort === 1'b1) begin
				abortCnt++;
			end
		end
		if (lapEvents[2] === 1'b1) begin
			tinCnt++;
		end
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic put(input logic [7:0] b, input logic l);
		hostTxValid <= 1'b1;
		hostTx <= '{data: b, last: l};
		do @(posedge clk); while (hostTxReady !== 1'b1);
		hostTxValid <= 1'b0;
		@(posedge clk);
	endtask

	// bit 8 of an expected octet marks a don't-care position
	function automatic logic found(input logic [8:0] exp[$]);
		for (int i = 0; i + exp.size() <= partner.txq.size(); i++) begin
			found = 1'b1;
			for (int j = 0; j < exp.size(); j++) begin
				if (!exp[j][8] && partner.txq[i + j] !== exp[j][7:0]) begin
					found = 1'b0;
				end
			end
			if (found) begin
				return 1'b1;
			end
		end
		return 1'b0;
	endfunction

	task automatic tx_expect(input string what, input logic [8:0] exp[$]);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 600 && !hit; k++) begin
			@(posedge clk);
			hit = found(exp);
		end
		check(what, 32'h1, {31'h0, hit});
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		hostTxValid = 1'b0;
		hostTx = '0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		apb(1'b0, 8'h08, 32'h0);
		check("user chars", 32'h7e7e7e7e, rd);
		apb(1'b0, 8'h0c, 32'h0);
		check("timer cfg", 32'h00030100, rd);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped err", 32'h1, {31'h0, er});
		apb(1'b1, 8'h04, 32'h00080000);
		apb(1'b0, 8'h04, 32'h0);
		check("char map", 32'h00080000, rd);
		$display("test registers done");
		apb(1'b1, 8'h00, 32'h000000e0);
		rxq.delete();
		partner.send(8'h7e, 1'b0);
		partner.send(8'h7d, 1'b1);
		repeat (2) @(posedge clk);
		check("xt rx", 32'h00027e7d, {8'h0, 8'(rxq.size()), rxq[0], rxq[1]});
		partner.txq.delete();
		put(8'h7e, 1'b0);
		put(8'h13, 1'b1);
		tx_expect("xt tx", '{9'h07e, 9'h013});
		$display("test transparent done");
		apb(1'b1, 8'h00, 32'h00000014);
		apb(1'b1, 8'h08, 32'h7e7e7ea5);
		rxq.delete();
		lastCnt = 0;
		abortCnt = 0;
		rxs = '{8'h7e, 8'h7d, 8'h33, 8'h13, 8'ha5, 8'h7d, 8'h85, 8'h7d, 8'h5d, 8'h41, 8'h7e,
			8'h42, 8'h7d, 8'h7e};
		foreach (rxs[i]) partner.send(rxs[i], 1'b0);
		repeat (2) @(posedge clk);
		check("ppp rx data", 32'h13a57d41, {rxq[0], rxq[1], rxq[2], rxq[3]});
		check("ppp rx tail", 32'h00000542, {16'h0, 8'(rxq.size()), rxq[4]});
		check("ppp frame ends", 32'h00020001, {16'(lastCnt), 16'(abortCnt)});
		check("abort flags", 32'h00000006, {29'h0, lastFlags});
		$display("test ppp receive done");
		partner.txq.delete();
		apb(1'b1, 8'h10, 32'h00000002);
		put(8'h7e, 1'b0);
		put(8'h13, 1'b0);
		put(8'ha5, 1'b1);
		tx_expect("ppp tx", '{9'h07e, 9'h07d, 9'h05e, 9'h07d, 9'h033, 9'h07d, 9'h085, 9'h051,
			9'h01b, 9'h07e});
		$display("test ppp transmit done");
		apb(1'b1, 8'h00, 32'h00000001);
		apb(1'b1, 8'h0c, 32'h00010008);
		tinCnt = 0;
		partner.txq.delete();
		apb(1'b1, 8'h10, 32'h00000001);
		put(8'h55, 1'b1);
		tx_expect("poll cmd", '{9'h07e, 9'h003, 9'h011});
		for (int k = 0; k < 3000 && tinCnt == 0; k++) @(posedge clk);
		check("timeout event", 32'h1, 32'(tinCnt));
		apb(1'b0, 8'h14, 32'h0);
		check("status", 32'h00000004, rd & 32'h00000fff);
		$display("test auto mode done");
		apb(1'b1, 8'h14, 32'h0000003f);
		rxq.delete();
		partner.txq.delete();
		rxs = '{8'h7e, 8'h01, 8'h00, 8'h42, 8'h06, 8'hfd, 8'h7e};
		foreach (rxs[i]) partner.send(rxs[i], 1'b0);
		repeat (2) @(posedge clk);
		check("i-frame rx", 32'h05010042, {8'(rxq.size()), rxq[0], rxq[1], rxq[2]});
		check("i-frame end", 32'h00000000, {29'h0, lastFlags});
		tx_expect("rr response", '{9'h07e, 9'h001, 9'h021});
		apb(1'b0, 8'h14, 32'h0);
		check("link status", 32'h00000808, rd & 32'h00000fff);
		$display("test link receive done");
		finish_test();
	end
endmodule // tb
`default_nettype wire
